// ===== inc/flrc_cfg.svh
// flrc_cfg.svh: opcodes, frame positions, field positions and timing counts.
// assumes a 20 MHz core clock and a single 3-byte addressed command set.
`ifndef FLRC_CFG_SVH
`define FLRC_CFG_SVH

`define FLRC_OP_NOP          8'h00
`define FLRC_OP_WRITE_EN     8'h06
`define FLRC_OP_LOCK_ONE     8'h36
`define FLRC_OP_UNLOCK_ONE   8'h39
`define FLRC_OP_READ_LOCK    8'h3D
`define FLRC_OP_SERIAL_NUM   8'h4B
`define FLRC_OP_PARAM_TBL    8'h5A
`define FLRC_OP_RESET_ARM    8'h66
`define FLRC_OP_RESUME       8'h7A
`define FLRC_OP_LOCK_ALL     8'h7E
`define FLRC_OP_UNLOCK_ALL   8'h98
`define FLRC_OP_RESET        8'h99

`define FLRC_OP_BITS         8'h08
`define FLRC_ADDR_END        8'h20
`define FLRC_SERIAL_START    8'h28
`define FLRC_PARAM_START     8'h28
`define FLRC_UID_BITS        8'h80
`define FLRC_UID_TOP         7'h7F
`define FLRC_CNT_WRAP        8'hA8
`define FLRC_BYTE_LAST       3'h7
`define FLRC_PARAM_FILL      8'hFF

`define FLRC_LOCKS           48
`define FLRC_BLK_MSB         19
`define FLRC_BLK_LSB         16
`define FLRC_SEC_MSB         15
`define FLRC_SEC_LSB         12
`define FLRC_BLK_FIRST       4'h0
`define FLRC_BLK_LAST        4'hF
`define FLRC_TOP_SEC_BASE    6'h10
`define FLRC_BLK_BASE        6'h20
`define FLRC_BP_SIZE_MSB     2
`define FLRC_BP_BOTTOM_BIT   3
`define FLRC_BP_NONE         3'h0
`define FLRC_BP_WHOLE        3'h5
`define FLRC_BLK_COUNT       5'h10

`define FLRC_CORE_PERIOD_NS  50
`define FLRC_RST_PULSE_MIN_NS 1000
`define FLRC_RST_PULSE_CYC \
	((`FLRC_RST_PULSE_MIN_NS + `FLRC_CORE_PERIOD_NS - 1) / `FLRC_CORE_PERIOD_NS)

`endif

// ===== inc/flrc_pkg.sv
// flrc_pkg: state types of the lock, reset and id command block.
// assumes flrc_cfg.svh on the include path.
`default_nettype none
`include "flrc_cfg.svh"

package flrc_pkg;

	typedef enum logic [2:0] {
		FLRC_ST_READY   = 3'h1,
		FLRC_ST_PIN_LOW = 3'h2,
		FLRC_ST_SOFT    = 3'h4
	} flrc_state_t;

	typedef struct packed {
		logic meta;
		logic sync;
	} flrc_sync_t;

	typedef struct packed {
		flrc_state_t               st;
		logic                      cs_prev;
		logic [`FLRC_LOCKS-1:0]    locks;
		logic                      write_enable_latch;
		logic                      write_in_progress;
		logic                      suspended_flag;
		logic                      fail;
		logic                      arm;
		logic [4:0]                pin_cnt;
		logic                      resume_p;
		logic                      abort_p;
		logic                      reset_p;
		logic                      prot;
	} flrc_core_t;

	typedef struct packed {
		logic [7:0]  cnt;
		logic [7:0]  op;
		logic [23:0] addr;
		logic [3:0]  dout;
	} flrc_link_t;

	typedef struct packed {
		logic       in_frame;
		logic [3:0] oe;
	} flrc_frame_t;

endpackage : flrc_pkg

`default_nettype wire

// ===== inc/flrc_prot_if.sv
// flrc_prot_if: address in, lock index, lock bit and protection verdict out.
// assumes the lookup side is purely combinational.
`default_nettype none
`include "flrc_cfg.svh"

interface flrc_prot_if;
	logic [23:0]            addr;
	logic                   scheme;
	logic                   cmp;
	logic [4:0]             bp;
	logic [`FLRC_LOCKS-1:0] locks;
	logic [5:0]             idx;
	logic                   lock_bit;
	logic                   blocked;

	modport user   (output addr, scheme, cmp, bp, locks, input idx, lock_bit, blocked);
	modport lookup (input addr, scheme, cmp, bp, locks, output idx, lock_bit, blocked);
endinterface : flrc_prot_if

`default_nettype wire

// ===== hdl/flrc_sync2.sv
// flrc_sync2: two-flop level synchroniser.
// assumes the input is a level that stays put for more than two clocks.
`default_nettype none

module flrc_sync2 #(
	parameter logic RST_VAL = 1'b1
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// level
	input  wire logic d_in,
	output logic      q_out
);
	import flrc_pkg::*;

	flrc_sync_t q;
	flrc_sync_t d;

	always_comb begin
		d.meta = d_in;
		d.sync = q.meta;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= {RST_VAL, RST_VAL};
		end else begin
			q <= d;
		end
	end

	assign q_out = q.sync;

endmodule : flrc_sync2

`default_nettype wire

// ===== hdl/flrc_prot.sv
// flrc_prot: maps an address to its lock slot and judges write protection.
// assumes 16 blocks of 64K, the first and last split into 4K sectors.
`default_nettype none
`include "flrc_cfg.svh"

module flrc_prot (
	// lookup request and answer
	flrc_prot_if.lookup pif
);
	import flrc_pkg::*;

	logic [3:0] blk;
	logic [3:0] sec;
	logic [2:0] n;
	logic [4:0] size;
	logic       in_rng;
	logic       lbit;

	always_comb begin
		blk = pif.addr[`FLRC_BLK_MSB:`FLRC_BLK_LSB];
		sec = pif.addr[`FLRC_SEC_MSB:`FLRC_SEC_LSB];
		if (blk == `FLRC_BLK_FIRST) begin
			pif.idx = {2'h0, sec};
		end else if (blk == `FLRC_BLK_LAST) begin
			pif.idx = `FLRC_TOP_SEC_BASE + {2'h0, sec};
		end else begin
			pif.idx = `FLRC_BLK_BASE + {2'h0, blk};
		end
		n = pif.bp[`FLRC_BP_SIZE_MSB:0];
		if (n == `FLRC_BP_NONE) begin
			size = 5'h00;
		end else if (n >= `FLRC_BP_WHOLE) begin
			size = `FLRC_BLK_COUNT;
		end else begin
			size = 5'h01 << (n - 3'h1);
		end
		if (pif.bp[`FLRC_BP_BOTTOM_BIT]) begin
			in_rng = {1'b0, blk} < size;
		end else begin
			in_rng = {1'b0, blk} >= (`FLRC_BLK_COUNT - size);
		end
		lbit = pif.locks[pif.idx];
		pif.lock_bit = lbit;
		pif.blocked = pif.scheme ? lbit : (in_rng ^ pif.cmp);
	end

endmodule : flrc_prot

`default_nettype wire

// ===== hdl/flrc_top.sv
// flrc_top: lock, reset, resume and id commands of a serial flash.
// assumes a host driving cs_n/sclk/sio; program and erase engines sit outside.
`default_nettype none
`include "flrc_cfg.svh"

module flrc_top #(
	parameter logic [127:0] SERIAL_NUMBER = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210 // arbitrary
) (
	// clocks and resets
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        sclk_in,
	input  wire logic        reset_pin_n_in,
	// serial link
	input  wire logic        cs_n_in,
	input  wire logic [3:0]  sio_in,
	output logic      [3:0]  sio_out,
	output logic      [3:0]  sio_oe_out,
	// configuration
	input  wire logic        quad_command_mode_in,
	input  wire logic        protect_scheme_select_in,
	input  wire logic        protect_complement_in,
	input  wire logic [4:0]  block_protect_field_in,
	input  wire logic [23:0] prot_addr_in,
	// operation events
	input  wire logic        op_start_in,
	input  wire logic        op_done_in,
	input  wire logic        suspend_done_in,
	input  wire logic        op_fail_in,
	// status
	output logic             write_enable_latch_out,
	output logic             write_in_progress_out,
	output logic             suspended_flag_out,
	output logic             prog_erase_fail_flag_out,
	output logic             prot_blocked_out,
	output logic             resume_out,
	output logic             abort_out,
	output logic             standby_reset_out
);
	import flrc_pkg::*;

	localparam logic [4:0] PIN_CYC = 5'(`FLRC_RST_PULSE_CYC);
	// a literal cannot be bit-selected, so the fill byte gets a name
	localparam logic [7:0] PARAM_FILL = `FLRC_PARAM_FILL;
	localparam flrc_core_t CORE_RST = '{st: FLRC_ST_READY, cs_prev: 1'b1, locks: '1,
		default: '0};

	flrc_core_t  q;
	flrc_core_t  d;
	flrc_link_t  lq;
	flrc_link_t  ld;
	flrc_frame_t fq;
	flrc_frame_t fd;

	logic        link_rst_n;
	logic        cs_sync;
	logic        pin_sync;
	logic        frame_end;
	logic        take;
	logic        on_byte;
	logic        on_addr;
	logic [7:0]  base;
	logic [3:0]  bits;
	logic [8:0]  sum;
	logic [7:0]  op_nx;
	logic [23:0] addr_nx;
	logic [3:0]  nib;
	logic        out_ph;

	flrc_prot_if cmd_pif ();
	flrc_prot_if rd_pif ();
	flrc_prot_if qry_pif ();

	// pin reset clears the link at once so the data pins float
	assign link_rst_n = resetn_in & reset_pin_n_in;

	flrc_sync2 #(.RST_VAL(1'b1)) u_cs_sync (
		.clk_in   (core_clk_in),
		.rst_n_in (resetn_in),
		.d_in     (cs_n_in),
		.q_out    (cs_sync)
	);

	flrc_sync2 #(.RST_VAL(1'b1)) u_pin_sync (
		.clk_in   (core_clk_in),
		.rst_n_in (resetn_in),
		.d_in     (reset_pin_n_in),
		.q_out    (pin_sync)
	);

	// lookups: command address, readout address, protection query
	assign cmd_pif.addr   = lq.addr;
	assign rd_pif.addr    = addr_nx;
	assign qry_pif.addr   = prot_addr_in;
	assign cmd_pif.scheme = protect_scheme_select_in;
	assign rd_pif.scheme  = protect_scheme_select_in;
	assign qry_pif.scheme = protect_scheme_select_in;
	assign cmd_pif.cmp    = protect_complement_in;
	assign rd_pif.cmp     = protect_complement_in;
	assign qry_pif.cmp    = protect_complement_in;
	assign cmd_pif.bp     = block_protect_field_in;
	assign rd_pif.bp      = block_protect_field_in;
	assign qry_pif.bp     = block_protect_field_in;
	assign cmd_pif.locks  = q.locks;
	assign rd_pif.locks   = q.locks;
	assign qry_pif.locks  = q.locks;

	flrc_prot u_cmd_prot (.pif(cmd_pif.lookup));
	flrc_prot u_rd_prot (.pif(rd_pif.lookup));
	flrc_prot u_qry_prot (.pif(qry_pif.lookup));

	function automatic logic out_bit(input logic [7:0] op, input logic [7:0] pos,
		input logic lk);
		logic [7:0] rel;
		logic       b;
		b = 1'b0;
		rel = pos - `FLRC_SERIAL_START;
		if (op == `FLRC_OP_READ_LOCK && pos >= `FLRC_ADDR_END) begin
			b = lk & (pos[2:0] == `FLRC_BYTE_LAST);
		end else if (op == `FLRC_OP_SERIAL_NUM && pos >= `FLRC_SERIAL_START
			&& rel < `FLRC_UID_BITS) begin
			b = SERIAL_NUMBER[`FLRC_UID_TOP - rel[6:0]];
		end else if (op == `FLRC_OP_PARAM_TBL && pos >= `FLRC_PARAM_START) begin
			b = PARAM_FILL[`FLRC_BYTE_LAST - pos[2:0]];
		end
		return b;
	endfunction : out_bit

	function automatic flrc_core_t to_defaults(input flrc_core_t s, input logic keep_fail);
		flrc_core_t r;
		r = s;
		r.locks = '1;
		r.write_enable_latch = 1'b0;
		r.write_in_progress = 1'b0;
		r.suspended_flag = 1'b0;
		r.arm = 1'b0;
		if (!keep_fail) begin
			r.fail = 1'b0;
		end
		return r;
	endfunction : to_defaults

	// link side: sclk domain, words handed over only while cs is high
	assign base = fq.in_frame ? lq.cnt : 8'h00;
	assign bits = quad_command_mode_in ? sio_in : {3'h0, sio_in[0]};
	assign sum = {1'b0, base} + (quad_command_mode_in ? 9'h004 : 9'h001);
	assign op_nx = (base >= `FLRC_OP_BITS) ? lq.op :
		quad_command_mode_in ? {lq.op[3:0], bits} : {lq.op[6:0], bits[0]};
	assign addr_nx = (base < `FLRC_OP_BITS || base >= `FLRC_ADDR_END) ? lq.addr :
		quad_command_mode_in ? {lq.addr[19:0], bits} : {lq.addr[22:0], bits[0]};

	always_comb begin
		ld = lq;
		fd.in_frame = 1'b1;
		nib = 4'h0;
		out_ph = 1'b0;
		if (!cs_n_in) begin
			ld.op = op_nx;
			ld.addr = addr_nx;
			// wrap keeps byte alignment for long reads
			ld.cnt = sum[8] ? `FLRC_CNT_WRAP : sum[7:0];
			for (int k = 0; k < 4; k++) begin
				nib[3 - k] = out_bit(op_nx, ld.cnt + 8'(k), rd_pif.lock_bit);
			end
			out_ph = (op_nx == `FLRC_OP_READ_LOCK && ld.cnt >= `FLRC_ADDR_END)
				|| (op_nx == `FLRC_OP_SERIAL_NUM && ld.cnt >= `FLRC_SERIAL_START)
				|| (op_nx == `FLRC_OP_PARAM_TBL && ld.cnt >= `FLRC_PARAM_START);
			ld.dout = quad_command_mode_in ? nib : {2'h0, nib[3], 1'b0};
		end
		fd.oe = !out_ph ? 4'h0 : (quad_command_mode_in ? 4'hF : 4'h2);
	end

	always_ff @(posedge sclk_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lq <= '0;
		end else begin
			lq <= ld;
		end
	end

	// frame flags end with cs itself since sclk may stop
	always_ff @(posedge sclk_in or posedge cs_n_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			fq <= '0;
		end else if (cs_n_in) begin
			fq <= '0;
		end else begin
			fq <= fd;
		end
	end

	// core side: link words are stable once synchronised cs is high
	assign frame_end = cs_sync & ~q.cs_prev;
	assign take = frame_end & pin_sync & (q.st == FLRC_ST_READY);
	assign on_byte = lq.cnt == `FLRC_OP_BITS;
	assign on_addr = lq.cnt == `FLRC_ADDR_END;

	always_comb begin
		d = q;
		d.cs_prev = cs_sync;
		d.resume_p = 1'b0;
		d.abort_p = 1'b0;
		d.reset_p = 1'b0;
		d.prot = qry_pif.blocked;
		if (op_done_in) begin
			d.write_enable_latch = 1'b0;
			d.write_in_progress = 1'b0;
		end
		case (q.st)
			FLRC_ST_READY: begin
				if (!pin_sync) begin
					d.st = FLRC_ST_PIN_LOW;
					d.pin_cnt = 5'h01;
				end else if (take) begin
					d.arm = 1'b0;
					if (lq.op == `FLRC_OP_RESET_ARM && on_byte) begin
						d.arm = 1'b1;
					end else if (lq.op == `FLRC_OP_RESET && on_byte && q.arm) begin
						d.st = FLRC_ST_SOFT;
					end else if (lq.op == `FLRC_OP_NOP) begin
						d.arm = 1'b0;
					end else if (lq.op == `FLRC_OP_WRITE_EN && on_byte) begin
						d.write_enable_latch = 1'b1;
					end else if (lq.op == `FLRC_OP_RESUME && on_byte && q.suspended_flag) begin
						d.write_enable_latch = 1'b1;
						d.write_in_progress = 1'b1;
						d.suspended_flag = 1'b0;
						d.resume_p = 1'b1;
					end else if (lq.op == `FLRC_OP_LOCK_ONE && on_addr && q.write_enable_latch) begin
						d.locks[cmd_pif.idx] = 1'b1;
						d.write_enable_latch = 1'b0;
					end else if (lq.op == `FLRC_OP_UNLOCK_ONE && on_addr && q.write_enable_latch) begin
						d.locks[cmd_pif.idx] = 1'b0;
						d.write_enable_latch = 1'b0;
					end else if (lq.op == `FLRC_OP_LOCK_ALL && on_byte && q.write_enable_latch) begin
						d.locks = '1;
						d.write_enable_latch = 1'b0;
					end else if (lq.op == `FLRC_OP_UNLOCK_ALL && on_byte && q.write_enable_latch) begin
						d.locks = '0;
						d.write_enable_latch = 1'b0;
					end
				end
			end
			FLRC_ST_PIN_LOW: begin
				// pulses shorter than the minimum are ignored
				if (pin_sync) begin
					d.st = FLRC_ST_READY;
				end else begin
					if (q.pin_cnt < PIN_CYC) begin
						d.pin_cnt = q.pin_cnt + 5'h01;
					end
					if (q.pin_cnt >= PIN_CYC - 5'h01) begin
						d = to_defaults(d, 1'b0);
					end
					if (q.pin_cnt == PIN_CYC - 5'h01) begin
						d.reset_p = 1'b1;
						d.abort_p = q.write_in_progress;
					end
				end
			end
			FLRC_ST_SOFT: begin
				d = to_defaults(d, 1'b1);
				d.reset_p = 1'b1;
				d.abort_p = q.write_in_progress;
				d.st = FLRC_ST_READY;
			end
			default: begin
				d.st = FLRC_ST_READY;
			end
		endcase
		// hardware events win over a clear in the same cycle
		if (op_start_in) begin
			d.write_in_progress = 1'b1;
		end
		if (op_fail_in) begin
			d.fail = 1'b1;
		end
		if (suspend_done_in) begin
			d.suspended_flag = 1'b1;
			d.write_enable_latch = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			q <= CORE_RST;
		end else begin
			q <= d;
		end
	end

	assign sio_out = lq.dout;
	assign sio_oe_out = fq.oe;
	assign write_enable_latch_out = q.write_enable_latch;
	assign write_in_progress_out = q.write_in_progress;
	assign suspended_flag_out = q.suspended_flag;
	assign prog_erase_fail_flag_out = q.fail;
	assign prot_blocked_out = q.prot;
	assign resume_out = q.resume_p;
	assign abort_out = q.abort_p;
	assign standby_reset_out = q.reset_p;

	property p_resume;
		@(posedge core_clk_in) disable iff (!resetn_in)
		take && lq.op == `FLRC_OP_RESUME && on_byte && q.suspended_flag && !suspend_done_in
		|=> q.write_enable_latch && q.write_in_progress && !q.suspended_flag && q.resume_p;
	endproperty
	a_resume: assert property (p_resume) else $error("resume flags wrong");

	property p_nop;
		@(posedge core_clk_in) disable iff (!resetn_in)
		take && lq.op == `FLRC_OP_NOP && !op_done_in && !suspend_done_in
		|=> !q.arm && $stable(q.locks) && q.write_enable_latch == $past(q.write_enable_latch);
	endproperty
	a_nop: assert property (p_nop) else $error("nop changed state");

	property p_lock_one;
		@(posedge core_clk_in) disable iff (!resetn_in)
		take && lq.op == `FLRC_OP_LOCK_ONE && on_addr && q.write_enable_latch
		|=> q.locks[$past(cmd_pif.idx)] && !q.write_enable_latch;
	endproperty
	a_lock_one: assert property (p_lock_one) else $error("block not locked");

	property p_boundary;
		@(posedge core_clk_in) disable iff (!resetn_in)
		take && (lq.op == `FLRC_OP_LOCK_ONE || lq.op == `FLRC_OP_UNLOCK_ONE) && !on_addr
		|=> $stable(q.locks);
	endproperty
	a_boundary: assert property (p_boundary) else $error("misaligned lock ran");

	property p_all;
		@(posedge core_clk_in) disable iff (!resetn_in)
		take && q.write_enable_latch && on_byte && (lq.op == `FLRC_OP_LOCK_ALL)
		|=> (&q.locks) ##1 q.locks == $past(q.locks);
	endproperty
	a_all: assert property (p_all) else $error("global lock failed");

	property p_none;
		@(posedge core_clk_in) disable iff (!resetn_in)
		take && q.write_enable_latch && on_byte && lq.op == `FLRC_OP_UNLOCK_ALL |=> q.locks == '0;
	endproperty
	a_none: assert property (p_none) else $error("global unlock failed");

	property p_unarmed;
		@(posedge core_clk_in) disable iff (!resetn_in)
		take && lq.op == `FLRC_OP_RESET && !q.arm |=> !q.reset_p [*2];
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("reset without arm");

	property p_abort;
		@(posedge core_clk_in) disable iff (!resetn_in)
		q.st == FLRC_ST_SOFT && q.write_in_progress && !op_start_in
		|=> q.abort_p && !q.write_in_progress && (&q.locks);
	endproperty
	a_abort: assert property (p_abort) else $error("busy op not aborted");

	property p_pin;
		@(posedge core_clk_in) disable iff (!resetn_in)
		q.st == FLRC_ST_PIN_LOW && !pin_sync && q.pin_cnt == PIN_CYC - 5'h01 && !op_fail_in
		|=> q.reset_p && (&q.locks) && !q.fail;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset missed");

	property p_hiz;
		@(posedge core_clk_in) disable iff (!resetn_in)
		!pin_sync && !reset_pin_n_in |-> sio_oe_out == 4'h0;
	endproperty
	a_hiz: assert property (p_hiz) else $error("driving during pin reset");

endmodule : flrc_top

`default_nettype wire

// ===== sim/flrc_host_model.sv
// flrc_host_model: host side of the serial link, sends frames on request.
// assumes the device samples on rising sclk and updates just after it.
`default_nettype none

module flrc_host_model (
	// link towards the device
	output logic            cs_n_out,
	output logic            sclk_out,
	output logic      [3:0] sio_out,
	// device answer and mode
	input  wire logic [3:0] sio_in,
	input  wire logic       quad_in
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sio_out  = 4'hA;
	end

	// sclk runs only inside frames; released lines toggle so stale bits never pass
	task automatic frame(input logic [63:0] tx, input int nb, input int nrx,
		output logic [127:0] rx);
		int i;
		rx = '0;
		#7 cs_n_out = 1'b0;
		for (i = 0; i < nb; i += (quad_in ? 4 : 1)) begin
			sio_out = quad_in ? tx[63-i -: 4] : {~sio_out[3:1], tx[63-i]};
			#15 sclk_out = 1'b1;
			#15 sclk_out = 1'b0;
		end
		for (i = 0; i < nrx; i++) begin
			sio_out = ~sio_out;
			#15 rx = {rx[126:0], sio_in[1]};
			sclk_out = 1'b1;
			#15 sclk_out = 1'b0;
		end
		#15 cs_n_out = 1'b1;
		sio_out = ~sio_out;
		#400;
	endtask : frame
endmodule : flrc_host_model

`default_nettype wire

// ===== sim/flrc_top_tb.sv
// flrc_top_tb: self-checking bench for lock, reset, resume and id commands.
// assumes flrc_host_model as link partner and the default lock slot layout.
`default_nettype none

module flrc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// arbitrary value
	localparam logic [127:0] SN = 128'h5A3C_0F96_1E2D_4B78_C3A5_6699_F00F_8421;
	// resume-to-suspend gap in core clocks, value arbitrary
	localparam int PROGRAM_RESUME_GAP = 100;
	logic         clk = 1'b0, rst_n = 1'b0, pin_n = 1'b1, quad = 1'b0;
	logic         scheme = 1'b1, cmp = 1'b0;
	logic [4:0]   bp = 5'h00;
	logic [23:0]  paddr = 24'h000000;
	logic [3:0]   ev = 4'h0, host, dout, oe, sio_w, oe_seen = 4'h0;
	logic         cs_n, sclk, write_enable_latch, write_in_progress, suspended_flag, fail, blk, res, abt, stby;
	logic [127:0] rx;
	int           errors = 0, checks = 0, n_abt = 0, n_stby = 0, n_res = 0;

	always #25 clk = ~clk;
	assign sio_w = (oe & dout) | (~oe & host);
	always @(negedge clk) begin
		if (abt === 1'b1) n_abt++;
		if (stby === 1'b1) n_stby++;
		if (res === 1'b1) n_res++;
	end
	always @(negedge sclk) if (pin_n === 1'b0) oe_seen |= oe;

	flrc_top #(.SERIAL_NUMBER(SN)) flrc_top_i (.core_clk_in(clk), .resetn_in(rst_n),
		.sclk_in(sclk), .reset_pin_n_in(pin_n), .cs_n_in(cs_n), .sio_in(sio_w),
		.sio_out(dout), .sio_oe_out(oe), .quad_command_mode_in(quad),
		.protect_scheme_select_in(scheme), .protect_complement_in(cmp),
		.block_protect_field_in(bp), .prot_addr_in(paddr), .op_start_in(ev[3]),
		.op_done_in(ev[2]), .suspend_done_in(ev[1]), .op_fail_in(ev[0]),
		.write_enable_latch_out(write_enable_latch), .write_in_progress_out(write_in_progress),
		.suspended_flag_out(suspended_flag), .prog_erase_fail_flag_out(fail),
		.prot_blocked_out(blk), .resume_out(res), .abort_out(abt),
		.standby_reset_out(stby));
	flrc_host_model flrc_host_model_i (.cs_n_out(cs_n), .sclk_out(sclk), .sio_out(host),
		.sio_in(sio_w), .quad_in(quad));

	task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nb,
		input int nrx);
		flrc_host_model_i.frame({op, a, 32'h0}, nb, nrx, rx);
	endtask : cmd
	task automatic wr_en();
		cmd(8'h06, 24'h0, 8, 0);
	endtask : wr_en
	task automatic look(input logic [23:0] a, input logic exp);
		@(negedge clk) paddr = a;
		repeat (3) @(negedge clk);
		chk("blocked", exp, blk);
	endtask : look
	task automatic pulse(input logic [3:0] m);
		@(negedge clk) ev = m;
		@(negedge clk) ev = 4'h0;
	endtask : pulse
	task automatic flags(input logic [3:0] e);
		chk("wel_wip_sus_fail", e, {write_enable_latch, write_in_progress, suspended_flag, fail});
	endtask : flags
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		#3_000_000;
		errors++;
		print_verdict();
	end

	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		#30_000;
		flags(4'h0);
		look(24'h050000, 1'b1);
		cmd(8'h39, 24'h050000, 32, 0);
		look(24'h050000, 1'b1);
		wr_en();
		flags(4'h8);
		cmd(8'h39, 24'h050000, 32, 0);
		look(24'h050000, 1'b0);
		flags(4'h0);
		cmd(8'h3D, 24'h05F000, 32, 8);
		chk("lock_state", 8'h00, rx[7:0]);
		cmd(8'h3D, 24'h060000, 32, 8);
		chk("lock_state", 8'h01, rx[7:0]);
		wr_en();
		cmd(8'h39, 24'h060000, 33, 0);
		look(24'h060000, 1'b1);
		wr_en();
		cmd(8'h36, 24'h050000, 32, 0);
		look(24'h050000, 1'b1);
		wr_en();
		cmd(8'h39, 24'h003000, 32, 0);
		look(24'h003000, 1'b0);
		look(24'h004000, 1'b1);
		$display("test single lock done");
		quad = 1'b1;
		wr_en();
		cmd(8'h98, 24'h0, 8, 0);
		look(24'h0F0000, 1'b0);
		quad = 1'b0;
		scheme = 1'b0;
		look(24'h0F0000, 1'b0);
		bp = 5'h05;
		look(24'h000000, 1'b1);
		cmp = 1'b1;
		look(24'h000000, 1'b0);
		scheme = 1'b1;
		wr_en();
		cmd(8'h7E, 24'h0, 8, 0);
		look(24'h0F0000, 1'b1);
		$display("test global lock done");
		pulse(4'h8);
		pulse(4'h2);
		flags(4'h6);
		cmd(8'h7A, 24'h0, 8, 0);
		flags(4'hC);
		chk("resume_pulses", 1, n_res);
		repeat (PROGRAM_RESUME_GAP) @(negedge clk);
		pulse(4'h2);
		flags(4'h6);
		cmd(8'h7A, 24'h0, 8, 0);
		flags(4'hC);
		chk("resume_pulses", 2, n_res);
		pulse(4'h4);
		$display("test resume done");
		wr_en();
		cmd(8'h98, 24'h0, 8, 0);
		pulse(4'h1);
		pulse(4'h8);
		cmd(8'h66, 24'h0, 8, 0);
		cmd(8'h00, 24'h0, 8, 0);
		cmd(8'h99, 24'h0, 8, 0);
		look(24'h0F0000, 1'b0);
		flags(4'h5);
		cmd(8'h66, 24'h0, 8, 0);
		cmd(8'h99, 24'h0, 8, 0);
		#30_000;
		look(24'h0F0000, 1'b1);
		flags(4'h1);
		chk("abort_pulses", 1, n_abt);
		chk("standby_pulses", 1, n_stby);
		$display("test soft reset done");
		wr_en();
		cmd(8'h98, 24'h0, 8, 0);
		@(negedge clk) pin_n = 1'b0;
		repeat (10) @(negedge clk);
		pin_n = 1'b1;
		look(24'h0F0000, 1'b0);
		pin_n = 1'b0;
		// a frame while the pin is low must see no driver
		cmd(8'h3D, 24'h0F0000, 32, 8);
		@(negedge clk) pin_n = 1'b1;
		#30_000;
		chk("oe_in_pin_reset", 4'h0, oe_seen);
		look(24'h0F0000, 1'b1);
		flags(4'h0);
		chk("standby_pulses", 2, n_stby);
		$display("test pin reset done");
		cmd(8'h4B, 24'h0, 40, 128);
		chk("serial_number", SN, rx);
		cmd(8'h5A, 24'h000010, 40, 16);
		chk("param_table", 16'hFFFF, rx[15:0]);
		$display("test id reads done");
		print_verdict();
	end
endmodule : flrc_top_tb

`default_nettype wire
